// >>> verilog/ifap_pkg.sv
// constants shared by the ferroelectric_store access port device end and host end
// Operation
// - 32 KB store, 1 KB maker, 31 KB user
// - key 46h then 57h at 302h enters config
// - key 57h then 46h leaves config
// - index 7 value 3 selects memory port
// - indexes 60h/61h set base high/low bytes
// - decode only after base set and activate bit0
// - decode base+0..base+3, ignore others; code ignores base bits 1:0 and decodes the aligned 4-byte block
// - offsets 0/1 address, offset 2 writes data
// - read offset 2 returns stored byte
// - control bit0 at base+3 enables auto increment
// - index/data ports only in config mode
// - logical device register index 7h, resets 01h
package ifap_pkg;
  localparam int          MEM_DEPTH     = 32768;
  localparam int          MEM_AW        = 15;
  localparam int          MAKER_BYTES   = 1024;
  localparam logic [15:0] CFG_INDEX_IO  = 16'h0302;
  localparam logic [15:0] CFG_DATA_IO   = 16'h0303;
  localparam logic [7:0]  KEY_A         = 8'h46;
  localparam logic [7:0]  KEY_B         = 8'h57;
  localparam logic [7:0]  IDX_LDN       = 8'h07;
  localparam logic [7:0]  IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0]  IDX_BASE_HI   = 8'h60;
  localparam logic [7:0]  IDX_BASE_LO   = 8'h61;
  localparam logic [7:0]  LDN_STORE     = 8'h03;
  localparam logic [7:0]  LDN_RESET     = 8'h01;
  localparam logic [1:0]  OFS_ADDR_LO   = 2'h0;
  localparam logic [1:0]  OFS_ADDR_HI   = 2'h1;
  localparam logic [1:0]  OFS_DATA      = 2'h2;
  localparam logic [1:0]  OFS_CTRL      = 2'h3;
  localparam logic [7:0]  FLOAT_BYTE    = 8'hff;
  // host end wishbone map
  localparam logic [3:0]  WB_CMD_OFS    = 4'h0;
  localparam logic [3:0]  WB_STAT_OFS   = 4'h4;
  localparam int          CMD_WE_BIT    = 16;
  localparam int          CMD_WD_LSB    = 24;
  localparam int          STAT_RD_LSB   = 8;
endpackage : ifap_pkg

// >>> verilog/ifap_link_if.sv
// i/o cycle link between the host end and the ferroelectric_store access port
`timescale 1ns/1ns
`default_nettype none
interface ifap_link_if;
  logic        io_req;    // cycle request, held until io_ack
  logic        io_we;     // 1 write, 0 read
  logic [15:0] io_addr;   // i/o address
  logic [7:0]  io_wdata;  // write byte
  logic        io_ack;    // one-cycle answer
  logic [7:0]  io_rdata;  // read byte, valid with io_ack
  modport dev  (input io_req, io_we, io_addr, io_wdata, output io_ack, io_rdata);
  modport host (output io_req, io_we, io_addr, io_wdata, input io_ack, io_rdata);
endinterface : ifap_link_if
`default_nettype wire

// >>> verilog/ifap_device.sv
// ferroelectric_store access port: config key, logical device regs and i/o mapped store
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ifap_device (
  input  wire logic                      clk_sys,      // system clock
  input  wire logic                      rstn,         // async reset, low
  ifap_link_if.dev                       link,         // i/o cycle link
  output logic                           cfg_mode,     // config mode open
  output logic                           port_active,  // memory port decoding
  output logic [ifap_pkg::MEM_AW-1:0]    mem_addr      // latched store address
);
  import ifap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic              cfg_r;
  logic              key_half_r;
  logic [7:0]        index_r;
  logic [7:0]        ldn_r;
  logic              act_r;
  logic [7:0]        base_hi_r;
  logic [7:0]        base_lo_r;
  logic              hi_set_r;
  logic              lo_set_r;
  logic [15:0]       maddr_r;
  logic              auto_inc_r;
  logic              ack_r;
  logic [7:0]        rdata_r;
  logic [7:0]        mem [0:MEM_DEPTH-1];

  logic              take;
  logic              wr;
  logic              rd;
  logic              at_index;
  logic              at_data;
  logic              sel_store;
  logic              decoding;
  logic              in_window;
  logic [1:0]        ofs;
  logic              data_access;
  logic [MEM_AW-1:0] widx;

  assign take        = link.io_req && !ack_r;
  assign wr          = take && link.io_we;
  assign rd          = take && !link.io_we;
  assign at_index    = link.io_addr == CFG_INDEX_IO;
  assign at_data     = link.io_addr == CFG_DATA_IO;
  assign sel_store   = ldn_r == LDN_STORE;
  assign decoding    = act_r && hi_set_r && lo_set_r;
  assign in_window   = decoding && link.io_addr[15:2] == {base_hi_r, base_lo_r[7:2]};
  assign ofs         = link.io_addr[1:0];
  assign data_access = take && in_window && ofs == OFS_DATA;
  assign widx        = maddr_r[MEM_AW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // configuration key
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_r      <= 1'b0;
      key_half_r <= 1'b0;
    end else if (wr && at_index) begin
      if (!cfg_r) begin
        if (key_half_r && link.io_wdata == KEY_B) begin
          cfg_r      <= 1'b1;
          key_half_r <= 1'b0;
        end else begin
          key_half_r <= link.io_wdata == KEY_A;
        end
      end else begin
        if (key_half_r && link.io_wdata == KEY_A) begin
          cfg_r      <= 1'b0;
          key_half_r <= 1'b0;
        end else begin
          key_half_r <= link.io_wdata == KEY_B;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // index and logical device registers, only in config mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      index_r <= 8'h00;
    end else if (wr && at_index && cfg_r) begin
      index_r <= link.io_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ldn_r <= LDN_RESET;
    end else if (wr && at_data && cfg_r && index_r == IDX_LDN) begin
      ldn_r <= link.io_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      act_r     <= 1'b0;
      base_hi_r <= 8'h00;
      base_lo_r <= 8'h00;
      hi_set_r  <= 1'b0;
      lo_set_r  <= 1'b0;
    end else if (wr && at_data && cfg_r && sel_store) begin
      unique case (index_r)
        IDX_ACTIVATE: act_r <= link.io_wdata[0];
        IDX_BASE_HI: begin
          base_hi_r <= link.io_wdata;
          hi_set_r  <= 1'b1;
        end
        IDX_BASE_LO: begin
          base_lo_r <= link.io_wdata;
          lo_set_r  <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i/o window: address latch, control bit, data port
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      maddr_r <= 16'h0000;
    end else if (wr && in_window && ofs == OFS_ADDR_LO) begin
      maddr_r[7:0] <= link.io_wdata;
    end else if (wr && in_window && ofs == OFS_ADDR_HI) begin
      maddr_r[15:8] <= {1'b0, link.io_wdata[6:0]};
    end else if (data_access && auto_inc_r) begin
      maddr_r <= {1'b0, widx + 15'h0001};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      auto_inc_r <= 1'b0;
    end else if (wr && in_window && ofs == OFS_CTRL) begin
      auto_inc_r <= link.io_wdata[0];
    end
  end

  // whole 32 KB array, maker area included; no reset, contents persist
  always_ff @(posedge clk_sys) begin
    if (data_access && link.io_we) begin
      mem[widx] <= link.io_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer: every cycle is acked once, unclaimed reads float high
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      if (in_window) begin
        unique case (ofs)
          OFS_ADDR_LO: rdata_r <= maddr_r[7:0];
          OFS_ADDR_HI: rdata_r <= maddr_r[15:8];
          OFS_DATA:    rdata_r <= mem[widx];
          OFS_CTRL:    rdata_r <= {7'h00, auto_inc_r};
        endcase
      end else if (cfg_r && at_data) begin
        if (index_r == IDX_LDN) begin
          rdata_r <= ldn_r;
        end else if (sel_store && index_r == IDX_ACTIVATE) begin
          rdata_r <= {7'h00, act_r};
        end else if (sel_store && index_r == IDX_BASE_HI) begin
          rdata_r <= base_hi_r;
        end else if (sel_store && index_r == IDX_BASE_LO) begin
          rdata_r <= base_lo_r;
        end else begin
          rdata_r <= 8'h00;
        end
      end else if (cfg_r && at_index) begin
        rdata_r <= index_r;
      end else begin
        rdata_r <= FLOAT_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_mode    <= 1'b0;
      port_active <= 1'b0;
      mem_addr    <= '0;
    end else begin
      cfg_mode    <= cfg_r;
      port_active <= decoding;
      mem_addr    <= widx;
    end
  end

  assign link.io_ack   = ack_r;
  assign link.io_rdata = rdata_r;
endmodule : ifap_device
`default_nettype wire

// >>> verilog/ifap_host.sv
// host end: wishbone command registers driving i/o cycles on the link
`timescale 1ns/1ns
`default_nettype none
module ifap_host (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        rstn,      // async reset, low
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // wishbone write
  input  wire logic [3:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte enables
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic [31:0]      wb_dat_o,  // read data
  output logic             wb_ack_o,  // wishbone ack
  output logic             busy,      // i/o cycle in flight
  ifap_link_if.host        link       // i/o cycle link
);
  import ifap_pkg::*;

  logic        req_r;
  logic        we_r;
  logic [15:0] addr_r;
  logic [7:0]  wdata_r;
  logic [7:0]  rdata_r;
  logic        wb_hit;
  logic        cmd_wr;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a command needs all four lanes; writes while busy are dropped
  assign cmd_wr = wb_hit && wb_we_i && wb_adr_i == WB_CMD_OFS
                  && wb_sel_i == 4'hf && !req_r;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, answers one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        WB_CMD_OFS:  wb_dat_o <= {wdata_r, 7'h00, we_r, addr_r};
        WB_STAT_OFS: wb_dat_o <= {16'h0000, rdata_r, 7'h00, req_r};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i/o cycle: held until the device acks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= 16'h0000;
      wdata_r <= 8'h00;
    end else if (cmd_wr) begin
      req_r   <= 1'b1;
      we_r    <= wb_dat_i[CMD_WE_BIT];
      addr_r  <= wb_dat_i[15:0];
      wdata_r <= wb_dat_i[CMD_WD_LSB +: 8];
    end else if (link.io_ack) begin
      req_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (req_r && link.io_ack && !we_r) begin
      rdata_r <= link.io_rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= cmd_wr || (req_r && !link.io_ack);
    end
  end

  assign link.io_req   = req_r;
  assign link.io_we    = we_r;
  assign link.io_addr  = addr_r;
  assign link.io_wdata = wdata_r;
endmodule : ifap_host
`default_nettype wire

// >>> verification/ifap_chk.sv
// link protocol assertions for the ferroelectric_store access port pair
`timescale 1ns/1ns
`default_nettype none
module ifap_chk (
  input wire logic        clk_sys,   // system clock
  input wire logic        rstn,      // async reset, low
  input wire logic        io_req,    // host request
  input wire logic        io_we,     // write flag
  input wire logic [15:0] io_addr,   // i/o address
  input wire logic [7:0]  io_wdata,  // write byte
  input wire logic        io_ack,    // device answer
  input wire logic [7:0]  io_rdata   // read byte
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    io_req && !io_ack;
  endsequence
  sequence s_answer;
    io_ack ##1 (!io_ack && !io_req);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_take_answer: assert property (s_take |=> s_answer)
    else $error("link request not answered after one cycle");
  a_ack_cause: assert property (io_ack |-> $past(io_req) && !$past(io_ack))
    else $error("answer without a pending request");
  a_req_steady: assert property (s_take |=> $stable(io_addr) && $stable(io_we) && $stable(io_wdata))
    else $error("request changed before answer");
  a_ack_pulse: assert property (io_ack |=> !io_ack)
    else $error("answer longer than one cycle");
  a_outside_float: assert property ((s_take and (!io_we && (io_addr == 16'h0314 || io_addr == 16'h030f)))
    |=> io_rdata == 8'hff)
    else $error("address outside window was claimed");
  a_rdata_cause: assert property ($changed(io_rdata) |-> $rose(io_ack) && !io_we)
    else $error("read byte changed outside a read answer");
  a_req_fresh: assert property ($rose(io_req) |-> !io_ack && !$past(io_ack))
    else $error("new request overlaps an answer");
  a_ack_bound: assert property (io_req |-> ##[0:1] io_ack)
    else $error("request waited too long");
endmodule : ifap_chk
`default_nettype wire

// >>> verification/tb_io_mapped_ferroelectric_store_access_port.sv
// self-checking bench for the ferroelectric_store access port host and device ends
`timescale 1ns/1ns
`default_nettype none
module tb_io_mapped_ferroelectric_store_access_port;
  import ifap_pkg::*;
  logic              clk_sys, rstn, cyc, stb, we, ack, busy, cfg_mode, port_active;
  logic [3:0]        adr, sel;
  logic [31:0]       dat_w, dat_r, got;
  logic [MEM_AW-1:0] mem_addr;
  logic [7:0]        rd;
  int                err_total, checks_done, cycles;
  ifap_link_if link ();
  ifap_host u_ifap_host (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .busy(busy), .link(link));
  ifap_device u_ifap_device (.clk_sys(clk_sys), .rstn(rstn), .link(link),
    .cfg_mode(cfg_mode), .port_active(port_active), .mem_addr(mem_addr));
  ifap_chk u_ifap_chk (.clk_sys(clk_sys), .rstn(rstn), .io_req(link.io_req),
    .io_we(link.io_we), .io_addr(link.io_addr), .io_wdata(link.io_wdata),
    .io_ack(link.io_ack), .io_rdata(link.io_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= s;
    dat_w <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    got = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  // one i/o cycle through the command register, then poll until done
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, WB_CMD_OFS, {d, 7'h00, w, a}, 4'hf);
    chk({15'h0, busy}, 16'h0001);
    do bus(1'b0, WB_STAT_OFS, 32'h0, 4'hf); while (got[0] !== 1'b0);
    chk({15'h0, busy}, 16'h0000);
    rd = got[15:8];
  endtask : io
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    io(1'b0, a, 8'h00);
    chk({8'h00, rd}, {8'h00, e});
  endtask : rdchk
  task automatic cfg(input logic [7:0] idx, input logic [7:0] v);
    wr(CFG_INDEX_IO, idx);
    wr(CFG_DATA_IO, v);
  endtask : cfg
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_config;
    cfg(IDX_LDN, LDN_STORE);
    rdchk(CFG_DATA_IO, 8'hff);
    wr(CFG_INDEX_IO, KEY_A);
    wr(CFG_INDEX_IO, KEY_B);
    chk({15'h0, cfg_mode}, 16'h0001);
    wr(CFG_INDEX_IO, IDX_LDN);
    rdchk(CFG_DATA_IO, LDN_RESET);
    wr(CFG_DATA_IO, LDN_STORE);
    rdchk(CFG_DATA_IO, LDN_STORE);
    cfg(IDX_BASE_HI, 8'h03);
    rdchk(CFG_DATA_IO, 8'h03);
    cfg(IDX_BASE_LO, 8'h10);
    rdchk(CFG_DATA_IO, 8'h10);
    rdchk(16'h0313, 8'hff);
    cfg(IDX_ACTIVATE, 8'h01);
    rdchk(CFG_DATA_IO, 8'h01);
    wr(CFG_INDEX_IO, KEY_B);
    wr(CFG_INDEX_IO, KEY_A);
    rdchk(CFG_DATA_IO, 8'hff);
    chk({14'h0, cfg_mode, port_active}, 16'h0001);
    $display("test config done");
  endtask : t_config
  task automatic t_store;
    wr(16'h0310, 8'h44);
    wr(16'h0311, 8'h01);
    wr(16'h0312, 8'h32);
    wr(16'h0310, 8'h01);
    wr(16'h0312, 8'h5a);
    wr(16'h0310, 8'h44);
    chk({1'b0, mem_addr}, 16'h0144);
    rdchk(16'h0312, 8'h32);
    wr(16'h0310, 8'h01);
    rdchk(16'h0312, 8'h5a);
    rdchk(16'h0314, 8'hff);
    rdchk(16'h030f, 8'hff);
    $display("test store done");
  endtask : t_store
  task automatic t_autoinc;
    wr(16'h0313, 8'h01);
    rdchk(16'h0313, 8'h01);
    wr(16'h0310, 8'hff);
    wr(16'h0311, 8'hff);
    chk({1'b0, mem_addr}, 16'h7fff);
    wr(16'h0312, 8'ha5);
    wr(16'h0312, 8'hc3);
    chk({1'b0, mem_addr}, 16'h0001);
    wr(16'h0310, 8'hff);
    wr(16'h0311, 8'h7f);
    rdchk(16'h0312, 8'ha5);
    rdchk(16'h0312, 8'hc3);
    wr(16'h0313, 8'h00);
    wr(16'h0310, 8'h00);
    wr(16'h0311, 8'h00);
    rdchk(16'h0312, 8'hc3);
    rdchk(16'h0312, 8'hc3);
    $display("test autoinc done");
  endtask : t_autoinc
  // partial-lane command is dropped; unmapped register reads zero
  task automatic t_refuse;
    bus(1'b1, WB_CMD_OFS, {8'h77, 7'h00, 1'b1, 16'h0310}, 4'h3);
    bus(1'b0, WB_STAT_OFS, 32'h0, 4'hf);
    chk({15'h0, got[0]}, 16'h0000);
    chk({15'h0, busy}, 16'h0000);
    bus(1'b0, WB_CMD_OFS, 32'h0, 4'hf);
    chk(got[15:0], 16'h0312);
    chk(got[31:16], 16'h0000);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk(got[15:0], 16'h0000);
    rdchk(16'h0310, 8'h00);
    $display("test refuse done");
  endtask : t_refuse
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      print_verdict();
    end
  end
  initial begin
    rstn  = 1'b0;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 4'h0;
    sel   = 4'h0;
    dat_w = 32'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    t_config();
    t_store();
    t_autoinc();
    t_refuse();
    print_verdict();
  end
endmodule : tb_io_mapped_ferroelectric_store_access_port
`default_nettype wire
